// File: pkg/pbu_regs.vh
// Purpose: Constants for the upper port pin control block
// Assumes: 8-bit register port, 4-bit register address
// Notes:   Offsets, field positions and reset values live here only
`ifndef PBU_REGS_VH
`define PBU_REGS_VH

// ==========================================================
// Register offsets
`define PBU_ADR_PINS 4'h0
`define PBU_ADR_LAT 4'h1
`define PBU_ADR_DIR 4'h2
`define PBU_ADR_ICM 4'h3
`define PBU_ADR_IC2 4'h4
`define PBU_ADR_IC3 4'h5
`define PBU_ADR_ANA 4'h6
`define PBU_ADR_STAT 4'h7
`define PBU_ADR_MASK 4'h8

// ==========================================================
// Reset values
`define PBU_RST_LAT 8'h00
`define PBU_RST_DIR 8'hFF
`define PBU_RST_ICM 8'h00
`define PBU_RST_IC2 8'hF5
`define PBU_RST_IC3 8'h00
`define PBU_RST_ANA 8'h00
`define PBU_RST_EVT 2'h0
`define PBU_RST_FILL 3'h0
`define PBU_RST_ANA_OUT 1'h1

// ==========================================================
// Field positions
`define PBU_ICM_CHG_EN 3
`define PBU_ICM_CHG_FLG 0
`define PBU_IC2_PU_DIS 7
`define PBU_IC2_EDGE2 4
`define PBU_IC3_EXT_IRQ_TWO_IN_EN 4
`define PBU_IC3_EXT_IRQ_TWO_IN_FLG 1
`define PBU_ANA_SEL3 3
`define PBU_EVT_CHG 0
`define PBU_EVT_EXT_IRQ_TWO_IN 1

// ==========================================================
// Implemented-bit masks
`define PBU_MSK_IC2 8'hF5
`define PBU_MSK_IC3 8'hDB
`define PBU_MSK_ANA 8'h3F

`endif

// File: hw/pbu_sync.v
// Purpose: Two-flop synchroniser for the port pin inputs
// Assumes: Pins are asynchronous to ref_clk_i
// Notes:   First stage is read only by the second stage
`timescale 1ns/1ps
module pbu_sync (
  // Clock and reset
  input wire ref_clk_i,
  input wire resetn_i,
  // Data
  input wire [7:0] async_i,
  output wire [7:0] sync_o
);

  reg [7:0] meta_q;
  reg [7:0] sync_q;

  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_q <= 8'h00;
      sync_q <= 8'h00;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule

// File: hw/pbu_pin_cell.v
// Purpose: Output driver, enable and pull-up control of one port pin
// Assumes: All inputs come from logic on ref_clk_i
// Notes:   Registered so the pad sees glitch-free levels
`timescale 1ns/1ps
module pbu_pin_cell (
  // Clock and reset
  input wire ref_clk_i,
  input wire resetn_i,
  // Stored controls
  input wire latch_i,
  input wire dir_i,
  input wire pu_global_i,
  // Peripheral override
  input wire ovr_en_i,
  input wire ovr_out_i,
  input wire ovr_oe_i,
  // Pad side
  output wire pad_out_o,
  output wire pad_oe_o,
  output wire pullup_o
);

  reg out_q;
  reg oe_q;
  reg pu_q;
  wire oe_d;

  // Override wins over the stored direction without touching it
  assign oe_d = ovr_en_i ? ovr_oe_i : ~dir_i;

  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      out_q <= 1'b0;
      oe_q <= 1'b0;
      pu_q <= 1'b0;
    end else begin
      out_q <= ovr_en_i ? ovr_out_i : latch_i;
      oe_q <= oe_d;
      pu_q <= pu_global_i & dir_i & ~oe_d;
    end
  end

  assign pad_out_o = out_q;
  assign pad_oe_o = oe_q;
  assign pullup_o = pu_q;

endmodule

// File: hw/pbu_port_top.v
// Purpose: Upper port pin control: registers, overrides, change and edge interrupts
// Assumes: One clock; pins enter through a two-flop synchroniser
// Notes:   Peripheral controls arrive from logic on the same clock
//
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`include "pbu_regs.vh"
module pbu_port_top (
  // Clock and reset
  input wire ref_clk_i,
  input wire resetn_i,
  // Register port
  input wire [3:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output wire [7:0] rdata_o,
  // Pads
  input wire [7:0] pad_in_i,
  output wire [7:0] pad_out_o,
  output wire [7:0] pad_oe_o,
  output wire [7:0] pullup_en_o,
  // Bus controller
  input wire bus_enable_i,
  input wire bus_transmit_out_i,
  output wire bus_receive_in_o,
  // Programming engine
  input wire low_volt_prog_entry_i,
  input wire prog_mode_i,
  input wire prog_data_out_i,
  input wire prog_data_oe_i,
  output wire prog_clock_pin_o,
  output wire prog_data_pin_o,
  // Analog converter
  output wire analog_channel_nine_o,
  // Interrupts
  output wire ext_irq_two_in_o,
  output wire port_change_irq_o,
  output wire ext_irq2_irq_o,
  output wire irq_o
);

  // ==========================================================
  // Decode

  function sel;
    input [3:0] a;
    input [3:0] off;
    begin
      sel = (a == off);
    end
  endfunction

  // Unmapped addresses select nothing and read as zero
  wire wr_pins = wr_i & sel(addr_i, `PBU_ADR_PINS);
  wire rd_pins = rd_i & sel(addr_i, `PBU_ADR_PINS);
  wire wr_lat = wr_i & sel(addr_i, `PBU_ADR_LAT);
  wire wr_dir = wr_i & sel(addr_i, `PBU_ADR_DIR);
  wire wr_icm = wr_i & sel(addr_i, `PBU_ADR_ICM);
  wire wr_ic2 = wr_i & sel(addr_i, `PBU_ADR_IC2);
  wire wr_ic3 = wr_i & sel(addr_i, `PBU_ADR_IC3);
  wire wr_ana = wr_i & sel(addr_i, `PBU_ADR_ANA);
  wire wr_stat = wr_i & sel(addr_i, `PBU_ADR_STAT);
  wire wr_mask = wr_i & sel(addr_i, `PBU_ADR_MASK);

  // ==========================================================
  // State

  reg [7:0] lat_q;
  reg [7:0] dir_q;
  reg [7:0] icm_q;
  reg [7:0] ic2_q;
  reg [7:0] ic3_q;
  reg [7:0] ana_q;
  reg [3:0] snap_q;
  reg ext_irq_two_in_prev_q;
  reg [1:0] stat_q;
  reg [1:0] mask_q;
  reg [7:0] rdata_q;
  reg [7:0] rdata_d;
  reg [7:0] icm_d;
  reg [7:0] ic3_d;
  reg [1:0] stat_d;

  // ==========================================================
  // Pin inputs

  wire [7:0] pins_s;

  pbu_sync u_sync (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .async_i(pad_in_i),
    .sync_o(pins_s)
  );

  // Pin 4 stays analog until software sets the select bit
  wire pin4_analog = ~ana_q[`PBU_ANA_SEL3];
  wire [7:0] pins_dig = pins_s & ~{3'b000, pin4_analog, 4'b0000};

  // Receive path works only if software left pin 3 an input
  wire rx_d = pins_s[3] & dir_q[3];
  assign prog_clock_pin_o = pins_s[6];
  assign prog_data_pin_o = pins_s[7];

  // ==========================================================
  // Start-up guard

  // The synchroniser shows zeros until real pin levels have passed both
  // stages; edges and mismatches seen before then are not pin activity
  reg [2:0] fill_q;
  wire armed = fill_q[2];
  wire prime = fill_q[1] & ~fill_q[2];

  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fill_q <= `PBU_RST_FILL;
    end else begin
      fill_q <= {fill_q[1:0], 1'b1};
    end
  end

  // ==========================================================
  // Overrides

  wire [7:0] ovr_en;
  wire [7:0] ovr_out;
  wire [7:0] ovr_oe;

  assign ovr_en = {prog_mode_i, prog_mode_i, low_volt_prog_entry_i, 2'b00,
                   bus_enable_i, 2'b00};
  assign ovr_out = {prog_data_out_i, 4'h0, bus_transmit_out_i, 2'b00};
  // Pin 5 and pin 6 overrides only ever release the driver
  assign ovr_oe = {prog_data_oe_i, 1'b0, 1'b0, 2'b00, 1'b1, 2'b00};

  wire pu_global = ~ic2_q[`PBU_IC2_PU_DIS];

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : gen_pin
      pbu_pin_cell u_cell (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .latch_i(lat_q[g]),
        .dir_i(dir_q[g]),
        .pu_global_i(pu_global),
        .ovr_en_i(ovr_en[g]),
        .ovr_out_i(ovr_out[g]),
        .ovr_oe_i(ovr_oe[g]),
        .pad_out_o(pad_out_o[g]),
        .pad_oe_o(pad_oe_o[g]),
        .pullup_o(pullup_en_o[g])
      );
    end
  endgenerate

  // ==========================================================
  // Change detect

  // Outputs are left out of the comparison so driving them is silent
  wire [3:0] chg_cmp = (pins_dig[7:4] ^ snap_q) & dir_q[7:4];
  wire mismatch = armed & (|chg_cmp);

  // A read or write of the pin register re-arms the comparison
  // The first snapshot is taken as soon as the synchroniser has filled
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      snap_q <= 4'h0;
    end else if (rd_pins | wr_pins | prime) begin
      snap_q <= pins_dig[7:4];
    end
  end

  // ==========================================================
  // External interrupt 2

  wire ext_irq_two_in_in = pins_s[2] & dir_q[2];
  // Edges are taken on the synced pin itself, so turning pin 2 into an
  // input while it sits high is not mistaken for an edge
  wire ext_irq_two_in_rise = armed & dir_q[2] & pins_s[2] & ~ext_irq_two_in_prev_q;
  wire ext_irq_two_in_fall = armed & dir_q[2] & ~pins_s[2] & ext_irq_two_in_prev_q;
  wire ext_irq_two_in_evt = ic2_q[`PBU_IC2_EDGE2] ? ext_irq_two_in_rise : ext_irq_two_in_fall;

  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ext_irq_two_in_prev_q <= 1'b0;
    end else begin
      ext_irq_two_in_prev_q <= pins_s[2];
    end
  end

  // ==========================================================
  // Output registers

  // Receive and external interrupt 2 inputs leave on flops, one cycle behind the synced pins; the programming pins do not
  reg rx_q;
  reg ext_irq_two_in_in_q;
  reg ana_out_q;

  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_q <= 1'b0;
      ext_irq_two_in_in_q <= 1'b0;
      ana_out_q <= `PBU_RST_ANA_OUT;
    end else begin
      rx_q <= rx_d;
      ext_irq_two_in_in_q <= ext_irq_two_in_in;
      ana_out_q <= pin4_analog;
    end
  end

  assign bus_receive_in_o = rx_q;
  assign ext_irq_two_in_o = ext_irq_two_in_in_q;
  assign analog_channel_nine_o = ana_out_q;

  // ==========================================================
  // Interrupt control registers

  // Hardware set wins over a software clear in the same cycle
  always @* begin
    icm_d = icm_q;
    if (wr_icm) begin
      icm_d = wdata_i;
    end
    if (mismatch) begin
      icm_d[`PBU_ICM_CHG_FLG] = 1'b1;
    end
  end

  always @* begin
    ic3_d = ic3_q;
    if (wr_ic3) begin
      ic3_d = wdata_i & `PBU_MSK_IC3;
    end
    if (ext_irq_two_in_evt) begin
      ic3_d[`PBU_IC3_EXT_IRQ_TWO_IN_FLG] = 1'b1;
    end
  end

  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      icm_q <= `PBU_RST_ICM;
      ic2_q <= `PBU_RST_IC2;
      ic3_q <= `PBU_RST_IC3;
      ana_q <= `PBU_RST_ANA;
    end else begin
      icm_q <= icm_d;
      ic3_q <= ic3_d;
      if (wr_ic2) begin
        ic2_q <= wdata_i & `PBU_MSK_IC2;
      end
      if (wr_ana) begin
        ana_q <= wdata_i & `PBU_MSK_ANA;
      end
    end
  end

  // Per-source levels for the core's own interrupt controller
  assign port_change_irq_o = icm_q[`PBU_ICM_CHG_FLG] & icm_q[`PBU_ICM_CHG_EN];
  assign ext_irq2_irq_o = ic3_q[`PBU_IC3_EXT_IRQ_TWO_IN_FLG] & ic3_q[`PBU_IC3_EXT_IRQ_TWO_IN_EN];

  // ==========================================================
  // Port latch and direction

  // Overrides never write these, so control resumes intact afterwards
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lat_q <= `PBU_RST_LAT;
      dir_q <= `PBU_RST_DIR;
    end else begin
      if (wr_pins | wr_lat) begin
        lat_q <= wdata_i;
      end
      if (wr_dir) begin
        dir_q <= wdata_i;
      end
    end
  end

  // ==========================================================
  // Event status and mask

  // Write one clears; an event in the same cycle wins
  always @* begin
    stat_d = stat_q;
    if (wr_stat) begin
      stat_d = stat_q & ~wdata_i[1:0];
    end
    if (mismatch) begin
      stat_d[`PBU_EVT_CHG] = 1'b1;
    end
    if (ext_irq_two_in_evt) begin
      stat_d[`PBU_EVT_EXT_IRQ_TWO_IN] = 1'b1;
    end
  end

  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stat_q <= `PBU_RST_EVT;
      mask_q <= `PBU_RST_EVT;
    end else begin
      stat_q <= stat_d;
      if (wr_mask) begin
        mask_q <= wdata_i[1:0];
      end
    end
  end

  assign irq_o = |(stat_q & mask_q);

  // ==========================================================
  // Read path

  always @* begin
    case (addr_i)
      `PBU_ADR_PINS: rdata_d = pins_dig;
      `PBU_ADR_LAT: rdata_d = lat_q;
      `PBU_ADR_DIR: rdata_d = dir_q;
      `PBU_ADR_ICM: rdata_d = icm_q;
      `PBU_ADR_IC2: rdata_d = ic2_q & `PBU_MSK_IC2;
      `PBU_ADR_IC3: rdata_d = ic3_q & `PBU_MSK_IC3;
      `PBU_ADR_ANA: rdata_d = ana_q & `PBU_MSK_ANA;
      `PBU_ADR_STAT: rdata_d = {6'h00, stat_q};
      `PBU_ADR_MASK: rdata_d = {6'h00, mask_q};
      default: rdata_d = 8'h00;
    endcase
  end

  // Data held only for the cycle after the read strobe
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_q <= 8'h00;
    end else if (rd_i) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign rdata_o = rdata_q;

endmodule

// File: sim/pbu_board_model.sv
// Purpose: Board circuitry seen by the port pads
// Assumes: Device driver wins over any external source
// Notes: Undriven pins settle through a board pull-down
`timescale 1ns/1ps
module pbu_board_model (
  // Device side
  input wire [7:0] pad_out_i,
  input wire [7:0] pad_oe_i,
  input wire [7:0] pullup_i,
  // External sources
  input wire [7:0] ext_val_i,
  input wire [7:0] ext_drv_i,
  output wire [7:0] pad_o
);
  // Weak pull-up only counts where nothing else drives
  assign pad_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_drv_i & ext_val_i)
    | (~pad_oe_i & ~ext_drv_i & pullup_i);
endmodule

// File: sim/pbu_port_checker.sv
// Purpose: Port-level checks of the upper port pin control
// Assumes: Pad outputs lag their controls by one cycle
// Notes: Pin inputs reach outputs two or three cycles later
`timescale 1ns/1ps
module pbu_port_checker (
  input wire ref_clk_i,
  input wire resetn_i,
  input wire [7:0] pad_in_i,
  input wire [7:0] pad_out_o,
  input wire [7:0] pad_oe_o,
  input wire [7:0] pullup_en_o,
  input wire bus_enable_i,
  input wire bus_transmit_out_i,
  input wire bus_receive_in_o,
  input wire low_volt_prog_entry_i,
  input wire prog_mode_i,
  input wire prog_data_out_i,
  input wire prog_data_oe_i,
  input wire prog_clock_pin_o,
  input wire prog_data_pin_o,
  input wire ext_irq_two_in_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  AST_TX: assert property (bus_enable_i |=> pad_oe_o[2] &&
    pad_out_o[2] == $past(bus_transmit_out_i)) else $error("pin2 not transmit");
  AST_LVP: assert property (low_volt_prog_entry_i |=> !pad_oe_o[5])
    else $error("pin5 driven in entry");
  AST_PGC: assert property (prog_mode_i |=> !pad_oe_o[6])
    else $error("pin6 driven in prog");
  AST_PGD: assert property (prog_mode_i |=> pad_oe_o[7] == $past(prog_data_oe_i) &&
    (!pad_oe_o[7] || pad_out_o[7] == $past(prog_data_out_i))) else $error("pin7 bad");
  AST_PU: assert property ((pullup_en_o & pad_oe_o) == 8'h00)
    else $error("pull-up on output");
  AST_RX: assert property (bus_receive_in_o |-> $past(pad_in_i[3], 3))
    else $error("receive bad");
  AST_EXT_IRQ_TWO_IN: assert property (ext_irq_two_in_o |-> $past(pad_in_i[2], 3))
    else $error("ext_irq_two_in input bad");
  AST_CLK: assert property ($past(resetn_i, 2) |->
    prog_clock_pin_o == $past(pad_in_i[6], 2)) else $error("prog clock bad");
  AST_PGDI: assert property ($past(resetn_i, 2) |->
    prog_data_pin_o == $past(pad_in_i[7], 2)) else $error("prog data in bad");
endmodule
bind pbu_port_top pbu_port_checker u_pbu_port_checker (.ref_clk_i(ref_clk_i),
  .resetn_i(resetn_i), .pad_in_i(pad_in_i), .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o),
  .pullup_en_o(pullup_en_o), .bus_enable_i(bus_enable_i),
  .bus_transmit_out_i(bus_transmit_out_i), .bus_receive_in_o(bus_receive_in_o),
  .low_volt_prog_entry_i(low_volt_prog_entry_i), .prog_mode_i(prog_mode_i),
  .prog_data_out_i(prog_data_out_i), .prog_data_oe_i(prog_data_oe_i),
  .prog_clock_pin_o(prog_clock_pin_o), .prog_data_pin_o(prog_data_pin_o),
  .ext_irq_two_in_o(ext_irq_two_in_o));

// File: sim/pbu_port_top_test.sv
// Purpose: Self-checking bench of the upper port pin control
// Assumes: Reads answer one cycle after the strobe
// Notes: Pads loop back through the board model
`timescale 1ns/1ps
`include "pbu_regs.vh"
module pbu_port_top_test;
  reg clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
  reg [3:0] adr = 4'h0;
  reg [7:0] wd = 8'h00, ev = 8'h10, ed = 8'hFF, v;
  reg ben = 1'b0, btx = 1'b0, lvp = 1'b0, pm = 1'b0, pdo = 1'b0, pde = 1'b0;
  wire [7:0] rdat, pin, pout, poe, pu;
  wire rx, pclk, pdat, ana, i2in, chg, i2, irq;
  integer num_errors = 0;
  integer checks = 0;
  pbu_port_top u_pbu_port_top (.ref_clk_i(clk), .resetn_i(rst_n), .addr_i(adr),
    .wdata_i(wd), .wr_i(wr), .rd_i(rd), .rdata_o(rdat), .pad_in_i(pin), .pad_out_o(pout),
    .pad_oe_o(poe), .pullup_en_o(pu), .bus_enable_i(ben), .bus_transmit_out_i(btx),
    .bus_receive_in_o(rx), .low_volt_prog_entry_i(lvp), .prog_mode_i(pm),
    .prog_data_out_i(pdo), .prog_data_oe_i(pde), .prog_clock_pin_o(pclk),
    .prog_data_pin_o(pdat), .analog_channel_nine_o(ana), .ext_irq_two_in_o(i2in),
    .port_change_irq_o(chg), .ext_irq2_irq_o(i2), .irq_o(irq));
  pbu_board_model u_pbu_board_model (.pad_out_i(pout), .pad_oe_i(poe), .pullup_i(pu),
    .ext_val_i(ev), .ext_drv_i(ed), .pad_o(pin));
  // ==========================================================
  // Shared tasks
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task tick(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  // A gap edge between strobes keeps each strobe a single assignment per step
  task wrr(input [3:0] a, input [7:0] d);
    begin
      @(posedge clk);
      adr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask
  task rdc(input [3:0] a, input [7:0] exp);
    begin
      @(posedge clk);
      adr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdat, exp);
    end
  endtask
  task stop_test;
    begin
      $display("errors=%0d checks=%0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  // ==========================================================
  // Scenarios
  task t_reset;
    begin
      tick(1);
      chk({7'h00, ana}, 8'h01);
      chk(pu | poe, 8'h00);
      rdc(`PBU_ADR_DIR, 8'hFF);
      rdc(`PBU_ADR_LAT, 8'h00);
      rdc(`PBU_ADR_ICM, 8'h00);
      rdc(`PBU_ADR_IC2, 8'hF5);
      rdc(`PBU_ADR_IC3, 8'h00);
      rdc(`PBU_ADR_ANA, 8'h00);
      rdc(`PBU_ADR_MASK, 8'h00);
      rdc(`PBU_ADR_PINS, 8'h00);
      rdc(4'hF, 8'h00);
    end
  endtask
  task t_unimpl;
    begin
      wrr(`PBU_ADR_IC2, 8'hFF);
      rdc(`PBU_ADR_IC2, 8'hF5);
      wrr(`PBU_ADR_IC3, 8'hFF);
      rdc(`PBU_ADR_IC3, 8'hDB);
      wrr(`PBU_ADR_IC3, 8'h00);
      rdc(`PBU_ADR_IC3, 8'h00);
      wrr(`PBU_ADR_ANA, 8'hFF);
      rdc(`PBU_ADR_ANA, 8'h3F);
      wrr(`PBU_ADR_IC2, 8'hF5);
      chk({7'h00, ana}, 8'h00);
      rdc(`PBU_ADR_PINS, 8'h10);
    end
  endtask
  task t_drive;
    begin
      ev <= 8'h30;
      ed <= 8'hF0;
      wrr(`PBU_ADR_LAT, 8'hA5);
      wrr(`PBU_ADR_DIR, 8'hF0);
      tick(2);
      chk(poe, 8'h0F);
      chk(pout & 8'h0F, 8'h05);
      tick(2);
      rdc(`PBU_ADR_PINS, 8'h35);
      wrr(`PBU_ADR_IC2, 8'h75);
      tick(2);
      chk(pu, 8'hF0);
      wrr(`PBU_ADR_IC2, 8'hF5);
      tick(2);
      chk(pu, 8'h00);
    end
  endtask
  task t_override;
    begin
      ev <= 8'h08;
      ed <= 8'h08;
      wrr(`PBU_ADR_LAT, 8'hFF);
      wrr(`PBU_ADR_DIR, 8'h08);
      @(posedge clk);
      ben <= 1'b1;
      lvp <= 1'b1;
      pm <= 1'b1;
      pde <= 1'b1;
      tick(3);
      chk(poe, 8'h97);
      chk(pout & 8'h97, 8'h13);
      chk({7'h00, rx}, 8'h01);
      rdc(`PBU_ADR_DIR, 8'h08);
      rdc(`PBU_ADR_LAT, 8'hFF);
      @(posedge clk);
      ben <= 1'b0;
      lvp <= 1'b0;
      pm <= 1'b0;
      wrr(`PBU_ADR_DIR, 8'h00);
      tick(3);
      chk({7'h00, rx}, 8'h00);
    end
  endtask
  task t_change;
    begin
      ev <= 8'h00;
      ed <= 8'hF0;
      wrr(`PBU_ADR_DIR, 8'hF0);
      tick(3);
      rdc(`PBU_ADR_PINS, 8'h0F);
      wrr(`PBU_ADR_ICM, 8'h08);
      rdc(`PBU_ADR_ICM, 8'h08);
      ev <= 8'h40;
      tick(4);
      chk({7'h00, chg}, 8'h01);
      chk({6'h00, pdat, pclk}, 8'h01);
      rdc(`PBU_ADR_ICM, 8'h09);
      rdc(`PBU_ADR_PINS, 8'h4F);
      wrr(`PBU_ADR_ICM, 8'h08);
      wrr(`PBU_ADR_DIR, 8'h70);
      tick(4);
      rdc(`PBU_ADR_ICM, 8'h08);
    end
  endtask
  task t_ext_irq_two_in;
    begin
      ev <= 8'h00;
      ed <= 8'h04;
      wrr(`PBU_ADR_DIR, 8'h04);
      wrr(`PBU_ADR_IC3, 8'h10);
      wrr(`PBU_ADR_STAT, 8'h03);
      wrr(`PBU_ADR_MASK, 8'h02);
      tick(3);
      chk({7'h00, irq}, 8'h00);
      ev <= 8'h04;
      tick(4);
      chk({6'h00, i2, irq}, 8'h03);
      chk({7'h00, i2in}, 8'h01);
      rdc(`PBU_ADR_IC3, 8'h12);
      rdc(`PBU_ADR_STAT, 8'h02);
      wrr(`PBU_ADR_MASK, 8'h00);
      tick(1);
      chk({7'h00, irq}, 8'h00);
      wrr(`PBU_ADR_MASK, 8'h02);
      tick(1);
      chk({7'h00, irq}, 8'h01);
      wrr(`PBU_ADR_STAT, 8'h02);
      tick(1);
      chk({7'h00, irq}, 8'h00);
    end
  endtask
  // ==========================================================
  // Clock, reset, sequence and watchdog
  initial begin
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_unimpl;
    t_drive;
    t_override;
    t_change;
    t_ext_irq_two_in;
    stop_test;
  end
  // Whole run is under 150 cycles; this span of 4000 cycles leaves ample margin
  initial begin
    #100000;
    num_errors = num_errors + 1;
    stop_test;
  end
endmodule
